// File: pkg/ofp_map.svh
`ifndef OFP_MAP_SVH
`define OFP_MAP_SVH

// Internal word address: 16-bit words, 1 MB simulation array
`define OFP_WAW          19
`define OFP_HP_W         16
`define OFP_PAGE_W       15

// Command/address word, 48 bits over three link cycles
`define OFP_CA_LAST      3'd5
`define OFP_CA_READ      47
`define OFP_CA_ERASE     46
`define OFP_CA_LINEAR    45
`define OFP_CA_HP_LSB    16

// Read latency in link cycles after the command/address phase
`define OFP_RD_LAT_M1    4'd5

// Program buffer wrap masks on word address bits [7:0]
`define OFP_BUF256_MASK  8'h7F
`define OFP_BUF512_MASK  8'hFF

// Sector layout in words
`define OFP_SMALL_AW     11
`define OFP_LARGE_AW     17
`define OFP_BOT1_LIM     19'h10000
`define OFP_BOT2_LIM     19'h08000
`define OFP_TOP1_LIM     19'h70000
`define OFP_TOP2_LIM     19'h78000

`define OFP_ERASED       16'hFFFF
`define OFP_FIFO_DEPTH   16

`endif

// File: pkg/ofp_pkg.sv
`include "ofp_map.svh"
`default_nettype none

package ofp_pkg;

    typedef logic [`OFP_WAW-1:0] ofp_waddr_t;

    typedef enum logic [1:0] {
        MAP_UNIFORM = 2'h0,
        MAP_BOTTOM  = 2'h1,
        MAP_TOP     = 2'h2,
        MAP_SPLIT   = 2'h3
    } ofp_sector_map_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_CA   = 6'h02,
        ST_LAT  = 6'h04,
        ST_RD   = 6'h08,
        ST_WR   = 6'h10,
        ST_HOLD = 6'h20
    } ofp_state_t;

    typedef struct packed {
        ofp_waddr_t  addr;
        logic [15:0] data;
    } ofp_pgm_t;

    typedef struct packed {
        logic       cs_n;
        logic       clk_t;
        logic       clk_c;
        logic [7:0] dq;
    } ofp_pins_t;

endpackage

`default_nettype wire

// File: core/ofp_fifo.sv
`default_nettype none

module ofp_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (wr_ptr_q[AW] == rd_ptr_q[AW]) ||
                         (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]);
    assign o_out_valid = (wr_ptr_q != rd_ptr_q);
    assign o_out_data  = mem[rd_ptr_q[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

endmodule // ofp_fifo

`default_nettype wire

// File: core/ofp_array.sv
`include "ofp_map.svh"
`default_nettype none

module ofp_array
    import ofp_pkg::*;
(
    input  wire logic            i_sys_clk,
    input  wire logic            i_nrst,
    input  wire ofp_waddr_t      i_rd_addr,
    output logic        [15:0]   o_rd_data,
    input  wire logic            i_pgm_valid,
    output logic                 o_pgm_ready,
    input  wire ofp_pgm_t        i_pgm,
    input  wire logic            i_ers_req,
    input  wire ofp_waddr_t      i_ers_addr,
    input  wire ofp_sector_map_t i_map,
    output logic                 o_busy
);
    logic [15:0] mem [2**`OFP_WAW];
    ofp_waddr_t  ers_ptr_q;
    ofp_waddr_t  ers_last_q;
    logic        ers_small_q;
    logic        ers_hit;
    logic        req_small;

    function automatic logic in_small(ofp_waddr_t a, ofp_sector_map_t m);
        logic b;
        logic t;
        b = ((m == MAP_BOTTOM) && (a < `OFP_BOT1_LIM)) ||
            ((m == MAP_SPLIT) && (a < `OFP_BOT2_LIM));
        t = ((m == MAP_TOP) && (a >= `OFP_TOP1_LIM)) ||
            ((m == MAP_SPLIT) && (a >= `OFP_TOP2_LIM));
        return b || t;
    endfunction

    // Array powers up erased; no reset can clear it
    initial begin
        for (int i = 0; i < 2**`OFP_WAW; i++) begin
            mem[i] = `OFP_ERASED;
        end
    end

    assign o_pgm_ready = !o_busy;
    assign req_small   = in_small(i_ers_addr, i_map);
    // Large sector skips the small sectors sharing its block
    assign ers_hit     = (in_small(ers_ptr_q, i_map) == ers_small_q);

    always_ff @(posedge i_sys_clk) begin
        o_rd_data <= mem[i_rd_addr];
        if (o_busy && ers_hit) begin
            mem[ers_ptr_q] <= `OFP_ERASED;
        end else if (i_pgm_valid && !o_busy) begin
            mem[i_pgm.addr] <= mem[i_pgm.addr] & i_pgm.data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_busy      <= 1'b0;
            ers_ptr_q   <= '0;
            ers_last_q  <= '0;
            ers_small_q <= 1'b0;
        end else if (o_busy) begin
            ers_ptr_q <= ers_ptr_q + 1'b1;
            if (ers_ptr_q == ers_last_q) begin
                o_busy <= 1'b0;
            end
        end else if (i_ers_req) begin
            o_busy      <= 1'b1;
            ers_small_q <= req_small;
            if (req_small) begin
                ers_ptr_q  <= {i_ers_addr[`OFP_WAW-1:`OFP_SMALL_AW],
                               {`OFP_SMALL_AW{1'b0}}};
                ers_last_q <= {i_ers_addr[`OFP_WAW-1:`OFP_SMALL_AW],
                               {`OFP_SMALL_AW{1'b1}}};
            end else begin
                ers_ptr_q  <= {i_ers_addr[`OFP_WAW-1:`OFP_LARGE_AW],
                               {`OFP_LARGE_AW{1'b0}}};
                ers_last_q <= {i_ers_addr[`OFP_WAW-1:`OFP_LARGE_AW],
                               {`OFP_LARGE_AW{1'b1}}};
            end
        end
    end

endmodule // ofp_array

`default_nettype wire

// File: core/ofp_port.sv
`include "ofp_map.svh"
`default_nettype none

module ofp_port
    import ofp_pkg::*;
(
    input  wire logic            i_sys_clk,
    input  wire logic            i_nrst,
    input  wire logic            i_cs_n,
    input  wire logic            i_bus_clock_true,
    input  wire logic            i_bus_clock_complement,
    input  wire logic            i_diff_clk,
    input  wire logic [7:0]      i_dq,
    output logic      [7:0]      o_dq,
    output logic                 o_dq_oe,
    output logic                 o_read_strobe,
    output logic                 o_read_strobe_oe,
    input  wire logic            i_wrap_page,
    input  wire logic            i_pgm_buf_512,
    input  wire ofp_sector_map_t i_sector_map,
    output logic                 o_busy,
    output logic                 o_wr_overflow
);
    ofp_pins_t              pins_in;
    ofp_pins_t              sync1_q;
    ofp_pins_t              sync2_q;
    logic                   clk_lvl;
    logic                   lvl_q;
    logic                   link_edge;
    logic                   rise;
    logic                   fall;
    logic                   cs_act;

    ofp_state_t             state_q;
    logic [2:0]             ca_cnt_q;
    logic [47:0]            ca_q;
    logic [47:0]            ca_next;
    logic                   ca_done;
    logic                   ca_read;
    logic                   ca_erase;
    logic                   ca_linear;
    logic [`OFP_HP_W-1:0]   ca_hp;
    ofp_waddr_t             start_addr;
    logic [3:0]             lat_cnt_q;
    logic                   lat_end;
    logic                   data_rise;
    logic                   data_fall;

    logic [15:0]            pgbuf_q [2][16];
    logic [3:0]             rd_ptr_q;
    logic                   cur_buf_q;
    logic                   linear_q;
    logic [15:0]            cur_word;

    logic [1:0]             f_left_q;
    logic [`OFP_PAGE_W-1:0] f_page_q;
    logic                   f_buf_q;
    logic [3:0]             f_idx_q;
    logic                   fw_v_q;
    logic                   fw_buf_q;
    logic [3:0]             fw_idx_q;
    ofp_waddr_t             arr_rd_addr;
    logic [15:0]            arr_rd_data;

    ofp_waddr_t             wr_addr_q;
    ofp_waddr_t             wr_addr_nx;
    logic [7:0]             buf_mask;
    logic [7:0]             wr_hi_q;
    logic                   word_done;
    logic                   pend_v_q;
    ofp_pgm_t               pend_q;
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    logic                   arr_pgm_ready;
    ofp_pgm_t               fifo_out;
    logic                   ers_req_q;
    ofp_waddr_t             ers_addr_q;

    // Chip select, clock and data pins are resynchronised; the link clock is only sampled
    assign pins_in = {i_cs_n, i_bus_clock_true, i_bus_clock_complement, i_dq};

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
        end
    end

    // Complement pin only counts in differential mode
    assign clk_lvl = i_diff_clk ? (sync2_q.clk_t & ~sync2_q.clk_c)
                                : sync2_q.clk_t;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            lvl_q <= 1'b0;
        end else begin
            lvl_q <= clk_lvl;
        end
    end

    // Work is done only on seen edges, so a parked clock just waits
    assign link_edge = clk_lvl ^ lvl_q;
    assign rise      = link_edge && clk_lvl;
    assign fall      = link_edge && !clk_lvl;
    assign cs_act    = !sync2_q.cs_n;

    assign ca_next    = {ca_q[39:0], sync2_q.dq};
    assign ca_done    = (state_q == ST_CA) && link_edge &&
                        (ca_cnt_q == `OFP_CA_LAST);
    assign ca_read    = ca_next[`OFP_CA_READ];
    assign ca_erase   = ca_next[`OFP_CA_ERASE];
    assign ca_linear  = ca_next[`OFP_CA_LINEAR];
    assign ca_hp      = ca_next[`OFP_CA_HP_LSB +: `OFP_HP_W];
    assign start_addr = {ca_hp, ca_next[2:0]};

    assign lat_end   = (state_q == ST_LAT) && rise &&
                       (lat_cnt_q == `OFP_RD_LAT_M1);
    assign data_rise = rise && ((state_q == ST_RD) || lat_end);
    assign data_fall = fall && (state_q == ST_RD);

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state_q <= ST_IDLE;
        end else if (!cs_act) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_CA;
                end
                ST_CA: begin
                    if (ca_done) begin
                        if (ca_read) begin
                            state_q <= ST_LAT;
                        end else if (ca_erase) begin
                            state_q <= ST_HOLD;
                        end else begin
                            state_q <= ST_WR;
                        end
                    end
                end
                ST_LAT: begin
                    if (lat_end) begin
                        state_q <= ST_RD;
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            ca_cnt_q  <= '0;
            ca_q      <= '0;
            lat_cnt_q <= '0;
        end else if (state_q == ST_IDLE) begin
            ca_cnt_q  <= '0;
            lat_cnt_q <= '0;
        end else begin
            if ((state_q == ST_CA) && link_edge) begin
                ca_q     <= ca_next;
                ca_cnt_q <= ca_cnt_q + 3'd1;
            end
            if ((state_q == ST_LAT) && rise && !lat_end) begin
                lat_cnt_q <= lat_cnt_q + 4'd1;
            end
        end
    end

    // Burst pointer inside the two-page buffer
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            rd_ptr_q  <= '0;
            cur_buf_q <= 1'b0;
            linear_q  <= 1'b0;
        end else if (ca_done && ca_read) begin
            rd_ptr_q  <= {ca_hp[0], ca_next[2:0]};
            cur_buf_q <= 1'b0;
            linear_q  <= ca_linear;
        end else if (data_fall) begin
            if (linear_q) begin
                rd_ptr_q <= rd_ptr_q + 4'd1;
                if (rd_ptr_q == 4'hF) begin
                    cur_buf_q <= !cur_buf_q;
                end
            end else if (i_wrap_page) begin
                rd_ptr_q <= rd_ptr_q + 4'd1;
            end else begin
                rd_ptr_q <= {rd_ptr_q[3], rd_ptr_q[2:0] + 3'd1};
            end
        end
    end

    assign cur_word = pgbuf_q[cur_buf_q][rd_ptr_q];

    // Page fetcher: start page, then one page ahead in linear mode
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            f_left_q <= '0;
            f_page_q <= '0;
            f_buf_q  <= 1'b0;
            f_idx_q  <= '0;
        end else if (ca_done && ca_read) begin
            f_page_q <= ca_hp[`OFP_HP_W-1:1];
            f_buf_q  <= 1'b0;
            f_idx_q  <= '0;
            f_left_q <= ca_linear ? 2'd2 : 2'd1;
        end else if (data_fall && linear_q && (rd_ptr_q == 4'hF)) begin
            f_left_q <= f_left_q + 2'd1;
        end else if (f_left_q != 2'd0) begin
            f_idx_q <= f_idx_q + 4'd1;
            if (f_idx_q == 4'hF) begin
                f_left_q <= f_left_q - 2'd1;
                f_page_q <= f_page_q + 1'b1;
                f_buf_q  <= !f_buf_q;
            end
        end
    end

    assign arr_rd_addr = {f_page_q, f_idx_q};

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            fw_v_q   <= 1'b0;
            fw_buf_q <= 1'b0;
            fw_idx_q <= '0;
        end else begin
            fw_v_q   <= (f_left_q != 2'd0);
            fw_buf_q <= f_buf_q;
            fw_idx_q <= f_idx_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (fw_v_q) begin
            pgbuf_q[fw_buf_q][fw_idx_q] <= arr_rd_data;
        end
    end

    // Pins are released the cycle deselect is seen
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || !cs_act) begin
            o_dq             <= '0;
            o_dq_oe          <= 1'b0;
            o_read_strobe    <= 1'b0;
            o_read_strobe_oe <= 1'b0;
        end else if (ca_done && ca_read) begin
            o_read_strobe_oe <= 1'b1;
            o_read_strobe    <= 1'b0;
        end else if (data_rise) begin
            o_dq          <= cur_word[15:8];
            o_dq_oe       <= 1'b1;
            o_read_strobe <= 1'b1;
        end else if (data_fall) begin
            o_dq          <= cur_word[7:0];
            o_read_strobe <= 1'b0;
        end
    end

    // Words beyond the buffer wrap inside the aligned buffer
    assign buf_mask   = i_pgm_buf_512 ? `OFP_BUF512_MASK
                                      : `OFP_BUF256_MASK;
    assign wr_addr_nx = {wr_addr_q[`OFP_WAW-1:8],
                         (wr_addr_q[7:0] & ~buf_mask) |
                         ((wr_addr_q[7:0] + 8'd1) & buf_mask)};
    assign word_done  = fall && (state_q == ST_WR);

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wr_addr_q <= '0;
            wr_hi_q   <= '0;
        end else if (ca_done) begin
            wr_addr_q <= start_addr;
        end else if ((state_q == ST_WR) && rise) begin
            wr_hi_q <= sync2_q.dq;
        end else if (word_done) begin
            wr_addr_q <= wr_addr_nx;
        end
    end

    // One holding word; a full FIFO during erase stalls it here
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            pend_v_q <= 1'b0;
            pend_q   <= '0;
        end else if (word_done) begin
            pend_v_q <= 1'b1;
            pend_q   <= '{addr: wr_addr_q, data: {wr_hi_q, sync2_q.dq}};
        end else if (fifo_in_ready) begin
            pend_v_q <= 1'b0;
        end
    end

    // Lost word flag; a loss in the clearing cycle wins
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_wr_overflow <= 1'b0;
        end else if (word_done && pend_v_q && !fifo_in_ready) begin
            o_wr_overflow <= 1'b1;
        end else if (ca_done) begin
            o_wr_overflow <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            ers_req_q  <= 1'b0;
            ers_addr_q <= '0;
        end else begin
            ers_req_q  <= ca_done && !ca_read && ca_erase;
            ers_addr_q <= start_addr;
        end
    end

    ofp_fifo #(
        .WIDTH ($bits(ofp_pgm_t)),
        .DEPTH (`OFP_FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (pend_v_q),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (pend_q),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (arr_pgm_ready),
        .o_out_data  (fifo_out)
    );

    ofp_array u_array (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_rd_addr   (arr_rd_addr),
        .o_rd_data   (arr_rd_data),
        .i_pgm_valid (fifo_out_valid),
        .o_pgm_ready (arr_pgm_ready),
        .i_pgm       (fifo_out),
        .i_ers_req   (ers_req_q),
        .i_ers_addr  (ers_addr_q),
        .i_map       (i_sector_map),
        .o_busy      (o_busy)
    );

endmodule // ofp_port

`default_nettype wire

// File: testbench/ofp_port_props.sv
`default_nettype none

module ofp_port_props (
    input wire logic       i_sys_clk,
    input wire logic       i_nrst,
    input wire logic       i_cs_n,
    input wire logic [7:0] o_dq,
    input wire logic       o_dq_oe,
    input wire logic       o_read_strobe,
    input wire logic       o_read_strobe_oe,
    input wire logic       o_busy,
    input wire logic       o_wr_overflow
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    // Six cycles cover the chip select synchroniser and the output flop
    AST_DESEL_QUIET: assert property (
        i_cs_n [*6] |-> !o_dq_oe && !o_read_strobe_oe)
        else $error("pins driven while deselected");
    AST_STB_TOGGLES: assert property (
        o_dq_oe |-> ##[1:16] ($changed(o_read_strobe) || !o_dq_oe))
        else $error("read strobe stalled in data phase");
    AST_DQ_WITH_STB: assert property (
        o_dq_oe && $past(o_dq_oe) && $changed(o_dq)
        |-> $changed(o_read_strobe))
        else $error("data moved without strobe edge");
    AST_FIRST_HIGH: assert property (
        $rose(o_dq_oe) |-> o_read_strobe && o_read_strobe_oe)
        else $error("first byte not marked by strobe high");
    AST_OE_PAIR: assert property (
        o_dq_oe |-> o_read_strobe_oe)
        else $error("data driven without strobe");
    AST_ALL_CLEAR: assert property (
        $fell(o_read_strobe_oe)
        |-> !o_dq_oe && !o_read_strobe && o_dq == 8'h00)
        else $error("outputs not cleared together");
    AST_OE_HOLD: assert property (
        o_read_strobe_oe && !i_cs_n |=> o_read_strobe_oe)
        else $error("strobe released while selected");
    AST_OVF_STICKY: assert property (
        o_wr_overflow && i_cs_n |=> o_wr_overflow)
        else $error("overflow cleared while deselected");
    AST_BUSY_MIN: assert property (
        $rose(o_busy) |-> o_busy [*8])
        else $error("erase busy too short");

    COV_READ: cover property ($rose(o_dq_oe));
    COV_ERASE: cover property ($fell(o_busy));
    COV_OVF: cover property ($rose(o_wr_overflow));
endmodule // ofp_port_props

bind ofp_port ofp_port_props u_props (.*);

`default_nettype wire

// File: testbench/ofp_host_model.sv
`default_nettype none

module ofp_host_model (
    input wire logic       i_sys_clk,
    input wire logic [7:0] i_dq,
    input wire logic       i_strobe,
    input wire logic       i_strobe_oe,
    output logic           o_cs_n,
    output logic           o_ck,
    output logic           o_ck_c,
    output logic     [7:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] q[$];
    logic [7:0]  hi_q;
    logic        stb_q = 1'b0;

    initial begin
        o_cs_n = 1'b1;
        o_ck = 1'b0;
        o_ck_c = 1'b1;
        o_dq = 8'h00;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    // Clock parked around each byte: data stays clear of the sampled edge
    task automatic send(input logic [7:0] b);
        o_dq <= b;
        wt(4);
        o_ck <= ~o_ck;
        o_ck_c <= o_ck;
        wt(4);
    endtask

    task automatic start(input logic [47:0] ca);
        o_cs_n <= 1'b0;
        wt(4);
        for (int i = 5; i >= 0; i--) send(ca[i*8 +: 8]);
    endtask

    // Released lines show the inverse so stale data cannot pass
    task automatic stop();
        o_dq <= ~o_dq;
        wt(1);
        o_cs_n <= 1'b1;
        wt(4);
    endtask

    task automatic wr(input logic [47:0] ca, input logic [15:0] d[$]);
        start(ca);
        foreach (d[i]) begin
            send(d[i][15:8]);
            send(d[i][7:0]);
        end
        stop();
    endtask

    task automatic rd(input logic [47:0] ca, input int n);
        q.delete();
        start(ca);
        o_dq <= ~o_dq;
        repeat (n + 5) begin
            wt(4);
            o_ck <= 1'b1;
            o_ck_c <= 1'b0;
            wt(4);
            o_ck <= 1'b0;
            o_ck_c <= 1'b1;
        end
        wt(4);
        stop();
    endtask

    task automatic noise();
        repeat (6) send(8'hA5);
    endtask

    always @(posedge i_sys_clk) begin
        stb_q <= i_strobe;
        if (i_strobe_oe && i_strobe && !stb_q)
            hi_q <= i_dq;
        if (i_strobe_oe && !i_strobe && stb_q)
            q.push_back({hi_q, i_dq});
    end
endmodule // ofp_host_model

`default_nettype wire

// File: testbench/ofp_port_bench.sv
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module ofp_port_bench
    import ofp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            i_sys_clk = 1'b0;
    logic            i_nrst;
    logic            i_cs_n;
    logic            i_bus_clock_true;
    logic            i_bus_clock_complement;
    logic            i_diff_clk;
    logic      [7:0] host_dq;
    wire       [7:0] i_dq;
    logic      [7:0] o_dq;
    logic            o_dq_oe;
    logic            o_read_strobe;
    logic            o_read_strobe_oe;
    logic            i_wrap_page;
    logic            i_pgm_buf_512;
    ofp_sector_map_t i_sector_map;
    logic            o_busy;
    logic            o_wr_overflow;
    int              n_mismatch = 0;
    int              num_checks = 0;
    int              cyc = 0;
    logic     [15:0] mem[int];

    assign i_dq = o_dq_oe ? o_dq : host_dq;
    always #5 i_sys_clk = ~i_sys_clk;

    ofp_host_model host (
        .i_sys_clk   (i_sys_clk),
        .i_dq        (i_dq),
        .i_strobe    (o_read_strobe),
        .i_strobe_oe (o_read_strobe_oe),
        .o_cs_n      (i_cs_n),
        .o_ck        (i_bus_clock_true),
        .o_ck_c      (i_bus_clock_complement),
        .o_dq        (host_dq)
    );

    ofp_port uut (.*);

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    function automatic logic [15:0] ev(input int a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction

    function automatic logic [47:0] ca(input logic r, e, l,
                                       input logic [18:0] a);
        return {r, e, l, 13'h0000, a[18:3], 13'h0000, a[2:0]};
    endfunction

    task automatic pgm(input logic [18:0] a, input logic [15:0] d[$]);
        int m;
        int x;
        m = i_pgm_buf_512 ? 255 : 127;
        host.wr(ca(1'b0, 1'b0, 1'b0, a), d);
        foreach (d[i]) begin
            x = (a & ~m) | ((a + i) & m);
            mem[x] = ev(x) & d[i];
        end
        wt(20);
    endtask

    task automatic rdchk(input logic l, input logic [18:0] a, input int n);
        int g;
        int x;
        g = i_wrap_page ? 16 : 8;
        host.rd(ca(1'b1, 1'b0, l, a), n);
        `CHK(host.q.size(), n)
        for (int i = 0; i < n; i++) begin
            x = l ? a + i : (a & ~(g - 1)) | ((a + i) & (g - 1));
            `CHK(host.q[i], ev(x))
        end
    endtask

    task automatic t_erased();
        `CHK({o_dq_oe, o_read_strobe_oe, o_busy, o_wr_overflow}, 4'h0)
        rdchk(1'b0, 19'h00206, 10);
        $display("test erased done");
    endtask

    task automatic t_prog();
        logic [18:0] base;
        logic [18:0] lo;
        for (int b = 0; b < 2; b++) begin
            i_pgm_buf_512 <= b[0];
            wt(2);
            base = b ? 19'h002FF : 19'h0017F;
            lo = b ? 19'h00200 : 19'h00100;
            pgm(base, '{16'h1234, 16'hABCD});
            pgm(base, '{16'hFF0F});
            rdchk(1'b1, base - 19'h00001, 4);
            rdchk(1'b1, lo, 2);
            // Programmed word inside the group exposes a wrong wrap
            rdchk(1'b0, lo + 19'h00006, 10);
        end
        $display("test program done");
    endtask

    task automatic t_burst();
        i_wrap_page <= 1'b1;
        wt(2);
        rdchk(1'b1, 19'h0016A, 40);
        rdchk(1'b0, 19'h0017A, 20);
        $display("test burst done");
    endtask

    task automatic t_erase();
        logic [15:0] fill[$];
        int t0;
        for (int i = 0; i < 20; i++) fill.push_back(16'h00FF);
        i_sector_map <= MAP_BOTTOM;
        pgm(19'h00800, '{16'h5A5A});
        host.start(ca(1'b0, 1'b1, 1'b0, 19'h0017F));
        host.stop();
        t0 = cyc;
        while (!o_busy && cyc - t0 < 20) wt(1);
        `CHK(o_busy, 1'b1)
        t0 = cyc;
        // Twenty words overrun the sixteen-deep buffer while erase blocks it
        host.wr(ca(1'b0, 1'b0, 1'b0, 19'h40000), fill);
        `CHK(o_wr_overflow, 1'b1)
        while (o_busy && cyc - t0 < 3000) wt(1);
        `CHK(cyc - t0 >= 2040 && cyc - t0 <= 2056, 1'b1)
        for (int a = 0; a < 2048; a++) mem.delete(a);
        rdchk(1'b1, 19'h007FE, 4);
        `CHK(o_wr_overflow, 1'b0)
        $display("test erase done");
    endtask

    task automatic t_maps();
        logic [18:0] a;
        for (int k = 0; k < 2; k++) begin
            i_sector_map <= k ? MAP_SPLIT : MAP_TOP;
            a = k ? 19'h07800 : 19'h7F800;
            pgm(a - 19'h00001, '{16'h00F0});
            pgm(a, '{16'h0F00});
            host.start(ca(1'b0, 1'b1, 1'b0, a + 19'h001AB));
            host.stop();
            // A large sector would still be busy here
            wt(2100);
            `CHK(o_busy, 1'b0)
            mem.delete(a);
            rdchk(1'b1, a - 19'h00002, 4);
        end
        $display("test sector maps done");
    endtask

    task automatic t_desel();
        host.noise();
        `CHK({o_dq_oe, o_read_strobe_oe}, 2'b00)
        i_diff_clk <= 1'b0;
        wt(2);
        rdchk(1'b1, 19'h00800, 2);
        $display("test deselect done");
    endtask

    initial begin
        i_nrst = 1'b0;
        i_diff_clk = 1'b1;
        i_wrap_page = 1'b0;
        i_pgm_buf_512 = 1'b0;
        i_sector_map = MAP_UNIFORM;
        wt(5);
        i_nrst <= 1'b1;
        wt(5);
        t_erased();
        t_prog();
        t_burst();
        t_erase();
        t_maps();
        t_desel();
        close_out();
    end
endmodule // ofp_port_bench

`default_nettype wire
